// ### bbcfg_regs.sv
// Purpose: Byte-wide baseband transmit and receive configuration registers.
// Assumes: Master issues one-cycle strobes; read data valid the cycle after.
// Notes: Unmapped reads return zero; unmapped writes are ignored.
module bbcfg_regs (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Register port
   input wire logic [bbcfg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [bbcfg_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [bbcfg_pkg::DATA_W-1:0] o_rdata,
   // Receive status from the demodulator
   input wire logic i_hdr_crc_ok,
   input wire logic i_hdr_crc_antenna,
   input wire logic i_sfd_found,
   input wire logic i_slot_start,
   input wire logic i_slot_second_half,
   input wire logic i_diversity_antenna,
   input wire bbcfg_pkg::bbcfg_det_type i_det,
   // Pins
   input wire logic i_serial_in_pin,
   output logic o_antenna_select_pin,
   output logic o_demod_ready_out,
   output logic o_cca,
   output logic o_conv_clk_src,
   // Datapath controls
   output bbcfg_pkg::bbcfg_tx_ctl_type o_tx_ctl,
   output bbcfg_pkg::bbcfg_rx_ctl_type o_rx_ctl,
   output bbcfg_pkg::bbcfg_conv_ctl_type o_conv_ctl,
   output logic o_diversity_active
);
   import bbcfg_pkg::*;

   logic [7:0] tx_service_field;
   logic [7:0] tx_length_high;
   logic [7:0] tx_length_low;
   logic [7:0] tx_config;
   logic [7:0] rx_config;
   logic [7:0] rx_tx_config;
   logic [7:0] converter_clock_test;
   logic [7:0] next_rdata;
   logic last_crc_antenna;
   logic serial_meta;
   logic serial_sync;
   logic hdr_seen;
   logic tx_div_en;
   logic rx_div_allowed;

   // Register writes; the bank latches any value so software can read it back
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         tx_service_field <= RST_REG;
         tx_length_high <= RST_REG;
         tx_length_low <= RST_REG;
         tx_config <= RST_REG;
         rx_config <= RST_REG;
         rx_tx_config <= RST_REG;
         converter_clock_test <= RST_REG;
      end else if (i_wr) begin
         unique case (i_addr)
            OFS_TX_SERVICE_FIELD: tx_service_field <= i_wdata;
            OFS_TX_LENGTH_HIGH: tx_length_high <= i_wdata;
            OFS_TX_LENGTH_LOW: tx_length_low <= i_wdata;
            OFS_TX_CONFIG: tx_config <= i_wdata;
            OFS_RX_CONFIG: rx_config <= i_wdata;
            OFS_RX_TX_CONFIG: rx_tx_config <= i_wdata;
            OFS_CONVERTER_CLOCK_TEST: converter_clock_test <= i_wdata;
            default: ;
         endcase
      end
   end

   // (R23) Readback decode
   always_comb begin
      unique case (i_addr)
         OFS_TX_SERVICE_FIELD: next_rdata = tx_service_field;
         OFS_TX_LENGTH_HIGH: next_rdata = tx_length_high;
         OFS_TX_LENGTH_LOW: next_rdata = tx_length_low;
         OFS_TX_CONFIG: next_rdata = tx_config;
         OFS_RX_CONFIG: next_rdata = rx_config;
         OFS_RX_TX_CONFIG: next_rdata = rx_tx_config;
         OFS_CONVERTER_CLOCK_TEST: next_rdata = converter_clock_test;
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || !i_rd) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // (R1) Service byte passed as written; controller owns bit meanings
   // (R3) Header length join
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_tx_ctl <= '0;
      end else begin
         o_tx_ctl.hdr_length <= {tx_length_high, tx_length_low};
         o_tx_ctl.service <= tx_service_field;
         // (R7) Test enable
         o_tx_ctl.test_enable <= tx_config[3];
         // (R6) Test pattern select
         o_tx_ctl.test_all_ones <= tx_config[3] & tx_config[4];
         o_tx_ctl.alt_bits <= tx_config[3] & ~tx_config[4];
         // (R18) Long length in short test
         o_tx_ctl.long_len_for_short <= rx_tx_config[4];
      end
   end

   // Receive controls, all inverted-sense bits turned into positive enables
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_rx_ctl <= '0;
      end else begin
         // (R10) Gain freeze
         o_rx_ctl.agc_freeze <= rx_config[7];
         // (R11) Estimate clock gating
         // (R16) Continuous clocks override
         o_rx_ctl.est_clk_en <= rx_tx_config[7] | ~rx_config[6] | hdr_seen;
         // (R12) Equalizer enables
         o_rx_ctl.isi_eq_en <= ~rx_config[5];
         o_rx_ctl.ici_eq_en <= ~rx_config[4];
         o_rx_ctl.ready_after_sfd <= rx_config[3];
         o_rx_ctl.single_antenna <= rx_config[0];
         o_rx_ctl.rx_clk_continuous <= rx_tx_config[7];
         // (R17) Input coupling
         o_rx_ctl.ac_coupling <= rx_tx_config[6];
         // (R20) Precursor field
         o_rx_ctl.precursor <= rx_tx_config[2:0];
      end
   end

   // Detection marker; stays until slot restart so gating holds through the packet
   // A delimiter in the restart cycle wins, so a detect is never lost
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         hdr_seen <= 1'b0;
      end else if (i_sfd_found) begin
         hdr_seen <= 1'b1;
      end else if (i_slot_start) begin
         hdr_seen <= 1'b0;
      end
   end

   // (R13) Demod ready timing; pulse from the chosen event
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_demod_ready_out <= 1'b0;
      end else begin
         o_demod_ready_out <= rx_config[3] ? i_sfd_found : i_hdr_crc_ok;
      end
   end

   // (R9) Remember antenna of last good header checksum
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         last_crc_antenna <= 1'b0;
      end else if (i_hdr_crc_ok) begin
         last_crc_antenna <= i_hdr_crc_antenna;
      end
   end

   assign tx_div_en = tx_config[1];
   // (R14) Slot diversity cut
   assign rx_div_allowed = ~rx_config[0] & ~(rx_config[2] & i_slot_second_half);

   // Antenna pin: transmit choice in test mode or while slot diversity is cut, receive choice otherwise
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_antenna_select_pin <= 1'b0;
         o_diversity_active <= 1'b0;
      end else begin
         o_diversity_active <= rx_div_allowed;
         if (tx_config[3]) begin
            // (R8) Fixed transmit antenna
            // (R9) Diversity transmit antenna
            o_antenna_select_pin <= tx_div_en ? last_crc_antenna : tx_config[2];
         end else if (rx_config[0]) begin
            // (R15) Single antenna acquire
            o_antenna_select_pin <= rx_config[1];
         end else if (rx_div_allowed) begin
            // (R15) Dual antenna acquire
            o_antenna_select_pin <= i_diversity_antenna;
         end else begin
            o_antenna_select_pin <= tx_div_en ? last_crc_antenna : tx_config[2];
         end
      end
   end

   // Serial pin is asynchronous; two stages before use
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         serial_meta <= 1'b0;
         serial_sync <= 1'b0;
      end else begin
         serial_meta <= i_serial_in_pin;
         serial_sync <= serial_meta;
      end
   end

   // (R21) Converter clock source
   // (R22) Converter clock gates
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_conv_ctl <= '0;
         o_conv_clk_src <= 1'b0;
      end else begin
         o_conv_ctl.clk_from_serial <= converter_clock_test[7];
         o_conv_ctl.clk_enable <= ~converter_clock_test[6:0];
         o_conv_clk_src <= converter_clock_test[7] ? serial_sync : 1'b0;
      end
   end

   // Channel assessment engine
   bbcfg_cca u_cca (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_mode(tx_config[6:5]),
      .i_sampled(rx_tx_config[3]),
      .i_early(tx_config[7]),
      .i_slot_start(i_slot_start),
      .i_det(i_det),
      .o_cca(o_cca)
   );
endmodule

// ### bbcfg_pkg.sv
// Purpose: Constants and carrier types for the baseband config register bank.
// Assumes: Byte-wide registers on a plain strobe port, 25 MHz system clock.
// Notes: Offsets are byte addresses; reset values are zero.
// How it works
// (R1) Controller may set service bit 7 to resolve length ambiguity at top rate.
// (R2) Controller sets service bit 2 for common reference oscillator, others zero.
// (R3) Header length is high byte (15:8) joined with low byte (7:0).
// (R4) Assessment mode: energy, carrier-or-quality, energy AND that, energy OR that.
// (R5) Controller programs rate zero and test config before transmit tests.
// (R6) Test select zero gives alternating bits, one gives all-ones chips.
// (R7) Test enable zero is normal operation, one invokes selected test.
// (R8) Diversity off: antenna pin follows transmit antenna choice bit.
// (R9) Diversity on: antenna pin follows antenna of last valid header checksum.
// (R10) Freeze bit one holds gain control frozen during packet reception.
// (R11) Estimate clock runs during acquisition at zero, only after detect at one.
// (R12) Each equalizer enabled when its bit is zero, disabled when one.
// (R13) Demod ready after header checksum at zero, after frame delimiter at one.
// (R14) Slot diversity on stops antenna diversity for last half of slot.
// (R15) Acquire on both antennas at zero; single antenna per choice bit at one.
// (R16) Continuous bit runs receive clocks always, overriding estimate clock gating.
// (R17) Coupling bit zero selects DC, one selects AC converter inputs.
// (R18) Short preamble test mode uses long preamble length register.
// (R19) Raw assessment follows detectors; sampled updates once per 20 us slot.
// (R20) Three-bit field gives precursor value for impulse response estimate.
// (R21) Converters clocked internally at zero, from serial input pin at one.
// (R22) Each converter clock gated off when its disable bit is one.
// (R23) Every configuration register reads back the last value written.
package bbcfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_TX_SERVICE_FIELD = 8'h0c;
   localparam logic [7:0] OFS_TX_LENGTH_HIGH = 8'h0e;
   localparam logic [7:0] OFS_TX_LENGTH_LOW = 8'h10;
   localparam logic [7:0] OFS_TX_CONFIG = 8'h12;
   localparam logic [7:0] OFS_RX_CONFIG = 8'h14;
   localparam logic [7:0] OFS_RX_TX_CONFIG = 8'h16;
   localparam logic [7:0] OFS_CONVERTER_CLOCK_TEST = 8'h18;
   localparam logic [7:0] RST_REG = 8'h00;
   // Timing of sampled assessment
   localparam int CLK_MHZ = 25;
   localparam int SLOT_NS = 20000;
   localparam int SAMPLE_LATE_NS = 18700;
   localparam int SAMPLE_EARLY_NS = 15800;
   localparam int SLOT_CYC = SLOT_NS * CLK_MHZ / 1000;
   localparam int SAMPLE_LATE_CYC = SAMPLE_LATE_NS * CLK_MHZ / 1000;
   localparam int SAMPLE_EARLY_CYC = SAMPLE_EARLY_NS * CLK_MHZ / 1000;
   localparam int SLOT_W = 10;
   // Assessment modes
   localparam logic [1:0] CCA_ENERGY = 2'h0;
   localparam logic [1:0] CCA_CSQ = 2'h1;
   localparam logic [1:0] CCA_AND = 2'h2;
   localparam logic [1:0] CCA_OR = 2'h3;

   // Detector inputs to channel assessment
   typedef struct packed {
      logic energy_threshold_flag;
      logic carrier_sense_primary;
      logic signal_quality_primary;
   } bbcfg_det_type;

   // Receive path controls
   typedef struct packed {
      logic agc_freeze;
      logic est_clk_en;
      logic isi_eq_en;
      logic ici_eq_en;
      logic ready_after_sfd;
      logic single_antenna;
      logic rx_clk_continuous;
      logic ac_coupling;
      logic [2:0] precursor;
   } bbcfg_rx_ctl_type;

   // Transmit path controls
   typedef struct packed {
      logic [15:0] hdr_length;
      logic [7:0] service;
      logic test_enable;
      logic test_all_ones;
      logic alt_bits;
      logic long_len_for_short;
   } bbcfg_tx_ctl_type;

   // Converter clock controls
   typedef struct packed {
      logic clk_from_serial;
      logic [6:0] clk_enable;
   } bbcfg_conv_ctl_type;
endpackage

// ### bbcfg_cca.sv
// Purpose: Clear channel assessment combiner, raw or slot-sampled.
// Assumes: Detector levels already synchronised to i_clk_sys.
// Notes: Sampled mode latches once per 20 us slot at the chosen sample time.
module bbcfg_cca (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Configuration
   input wire logic [1:0] i_mode,
   input wire logic i_sampled,
   input wire logic i_early,
   input wire logic i_slot_start,
   // Detectors
   input wire bbcfg_pkg::bbcfg_det_type i_det,
   // Result
   output logic o_cca
);
   import bbcfg_pkg::*;

   logic raw;
   logic csq;
   logic held;
   logic [SLOT_W-1:0] slot_cnt;
   logic [SLOT_W-1:0] sample_at;

   // (R4) Mode combine
   always_comb begin
      csq = i_det.carrier_sense_primary | i_det.signal_quality_primary;
      unique case (i_mode)
         CCA_ENERGY: raw = i_det.energy_threshold_flag;
         CCA_CSQ: raw = csq;
         CCA_AND: raw = i_det.energy_threshold_flag & csq;
         CCA_OR: raw = i_det.energy_threshold_flag | csq;
      endcase
   end

   // Slot counter restarts on the slot boundary pulse so slots stay aligned
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n || i_slot_start || slot_cnt == SLOT_W'(SLOT_CYC - 1)) begin
         slot_cnt <= '0;
      end else begin
         slot_cnt <= slot_cnt + 1'b1;
      end
   end

   assign sample_at = i_early ? SLOT_W'(SAMPLE_EARLY_CYC) : SLOT_W'(SAMPLE_LATE_CYC);

   // (R19) Slot sampling
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         held <= 1'b0;
      end else if (slot_cnt == sample_at) begin
         held <= raw;
      end
   end

   // (R19) Raw or sampled
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         o_cca <= 1'b0;
      end else begin
         o_cca <= i_sampled ? held : raw;
      end
   end
endmodule

// ### bbcfg_regs_properties.sv
// Purpose: Port-level properties of the baseband config bank.
// Assumes: Shadow copies track writes on the same edge as the bank.
// Notes: Derived controls settle two edges after a write strobe.
module bbcfg_regs_properties (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Status, pins and controls
   input wire logic i_hdr_crc_ok,
   input wire logic i_sfd_found,
   input wire bbcfg_pkg::bbcfg_det_type i_det,
   input wire logic o_antenna_select_pin,
   input wire logic o_demod_ready_out,
   input wire logic o_cca,
   input wire bbcfg_pkg::bbcfg_tx_ctl_type o_tx_ctl,
   input wire bbcfg_pkg::bbcfg_conv_ctl_type o_conv_ctl
);
   timeunit 1ns;
   timeprecision 1ps;
   import bbcfg_pkg::*;
   logic [7:0] sh_tx, sh_rx, sh_rt;
   logic mapped, csq, comb, cause;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // Shadow mode registers, so properties need no view inside the bank
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         sh_tx <= 8'h00;
         sh_rx <= 8'h00;
         sh_rt <= 8'h00;
      end else if (i_wr) begin
         if (i_addr == OFS_TX_CONFIG) sh_tx <= i_wdata;
         if (i_addr == OFS_RX_CONFIG) sh_rx <= i_wdata;
         if (i_addr == OFS_RX_TX_CONFIG) sh_rt <= i_wdata;
      end
   end
   // Expected combiner and ready cause
   assign mapped = i_addr >= OFS_TX_SERVICE_FIELD && i_addr <= OFS_CONVERTER_CLOCK_TEST && !i_addr[0];
   assign csq = i_det.carrier_sense_primary | i_det.signal_quality_primary;
   assign comb = sh_tx[6:5] == CCA_ENERGY ? i_det.energy_threshold_flag : sh_tx[6:5] == CCA_CSQ ? csq :
      sh_tx[6:5] == CCA_AND ? i_det.energy_threshold_flag & csq : i_det.energy_threshold_flag | csq;
   assign cause = sh_rx[3] ? i_sfd_found : i_hdr_crc_ok;
   property p_readback;
      i_wr && mapped ##1 i_rd && !i_wr && i_addr == $past(i_addr) |=> o_rdata == $past(i_wdata, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("read data not last write");
   property p_rd_idle;
      !(i_rd && mapped) |=> o_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_len_hi;
      i_wr && i_addr == OFS_TX_LENGTH_HIGH |-> ##2 o_tx_ctl.hdr_length[15:8] == $past(i_wdata, 2);
   endproperty
   a_len_hi: assert property (p_len_hi) else $error("length high byte wrong");
   property p_cca;
      !sh_rt[3] |=> o_cca == $past(comb);
   endproperty
   a_cca: assert property (p_cca) else $error("raw assessment wrong");
   property p_test;
      i_wr && i_addr == OFS_TX_CONFIG |-> ##2 o_tx_ctl.test_enable == $past(i_wdata[3], 2);
   endproperty
   a_test: assert property (p_test) else $error("test enable wrong");
   property p_ant_single;
      !sh_tx[3] && sh_rx[0] |=> o_antenna_select_pin == $past(sh_rx[1]);
   endproperty
   a_ant_single: assert property (p_ant_single) else $error("single antenna pin wrong");
   property p_ready;
      1'b1 |=> o_demod_ready_out == $past(cause);
   endproperty
   a_ready: assert property (p_ready) else $error("demod ready timing wrong");
   property p_conv;
      i_wr && i_addr == OFS_CONVERTER_CLOCK_TEST |-> ##2 o_conv_ctl.clk_enable == ~$past(i_wdata[6:0], 2);
   endproperty
   a_conv: assert property (p_conv) else $error("converter clock gate wrong");
endmodule

bind bbcfg_regs bbcfg_regs_properties chk_u (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .i_hdr_crc_ok, .i_sfd_found, .i_det, .o_antenna_select_pin, .o_demod_ready_out, .o_cca, .o_tx_ctl, .o_conv_ctl);

// ### bbcfg_mac_model.sv
// Purpose: Controller model that programs the config bank.
// Assumes: One-cycle strobes; read data one cycle after the strobe.
// Notes: Never waits, the bank has no stall signal.
module bbcfg_mac_model #(
   parameter logic [7:0] SIG_OFS = 8'h0a,
   parameter logic [7:0] TCFG_OFS = 8'h40
) (
   // Clock
   input wire logic i_clk_sys,
   // Register port
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd,
   input wire logic [7:0] i_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import bbcfg_pkg::*;
   // Idle bus at time zero
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // Write cycle; data inverted after release so stale data never matches
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   // Read cycle; data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_rd <= 1'b0;
      #1;
      d = i_rdata;
   endtask
   // Write then read back with no gap between the strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk_sys);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_wr <= 1'b0;
      o_rd <= 1'b1;
      o_wdata <= ~d;
      @(posedge i_clk_sys);
      o_rd <= 1'b0;
      #1;
      q = i_rdata;
   endtask
   function automatic logic [7:0] service(input logic common_ref, input logic len_ext);
      return {len_ext, 4'h0, common_ref, 2'h0};
   endfunction
   task automatic test_prep();
      wr(SIG_OFS, 8'h00);
      wr(TCFG_OFS, 8'h0c);
   endtask
endmodule

// ### bbcfg_regs_tb_top.sv
// Purpose: Self-checking bench for the baseband config bank.
// Assumes: 25 MHz clock, synchronous active-low reset.
// Notes: Sampled assessment checks allow five cycles of slack.
module bbcfg_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bbcfg_pkg::*;
   logic i_clk_sys, i_rst_n, crc_ant, half, div_ant, ser, ant, rdy, cca, csrc, div_act;
   logic [2:0] pls;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd;
   bbcfg_det_type det;
   bbcfg_tx_ctl_type tx;
   bbcfg_rx_ctl_type rx;
   bbcfg_conv_ctl_type conv;
   int n_errors = 0;
   int check_count = 0;
   bbcfg_mac_model mac_u (.i_clk_sys, .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
   bbcfg_regs dut_u (.i_clk_sys, .i_rst_n, .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_hdr_crc_ok(pls[0]), .i_hdr_crc_antenna(crc_ant), .i_sfd_found(pls[1]), .i_slot_start(pls[2]),
      .i_slot_second_half(half), .i_diversity_antenna(div_ant), .i_det(det), .i_serial_in_pin(ser),
      .o_antenna_select_pin(ant), .o_demod_ready_out(rdy), .o_cca(cca), .o_conv_clk_src(csrc),
      .o_tx_ctl(tx), .o_rx_ctl(rx), .o_conv_ctl(conv), .o_diversity_active(div_act));
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   // One-cycle status pulses: bit0 checksum, bit1 delimiter, bit2 slot
   task automatic pulse(input logic [2:0] m);
      @(posedge i_clk_sys);
      pls <= m;
      @(posedge i_clk_sys);
      pls <= 3'h0;
      #1;
   endtask
   task automatic t_regs();
      logic [7:0] d;
      for (int i = 0; i < 7; i++) begin
         mac_u.rd(OFS_TX_SERVICE_FIELD + 8'(2 * i), d);
         chk(d, 0);
      end
      mac_u.test_prep();
      for (int i = 0; i < 7; i++) mac_u.wr(OFS_TX_SERVICE_FIELD + 8'(2 * i), 8'h31 + 8'(i));
      for (int i = 0; i < 9; i++) begin
         mac_u.rd(OFS_TX_SERVICE_FIELD + 8'(2 * i), d);
         chk(d, i < 7 ? 8'h31 + i : 0);
      end
      mac_u.wr_rd(OFS_RX_CONFIG, 8'h5a, d);
      chk(d, 8'h5a);
      mac_u.rd(8'h0d, d);
      chk(d, 0);
      mac_u.wr(OFS_TX_LENGTH_HIGH, 8'ha5);
      mac_u.wr(OFS_TX_LENGTH_LOW, 8'h3c);
      mac_u.wr(OFS_TX_SERVICE_FIELD, mac_u.service(1'b1, 1'b1));
      settle(2);
      chk(tx.hdr_length, 16'ha53c);
      chk(tx.service, 8'h84);
   endtask
   task automatic t_tx(input logic [7:0] c, input logic [2:0] e);
      mac_u.wr(OFS_TX_CONFIG, c);
      settle(2);
      chk({tx.test_enable, tx.test_all_ones, tx.alt_bits}, e);
   endtask
   task automatic t_cca();
      logic e;
      mac_u.wr(OFS_RX_TX_CONFIG, 8'h00);
      for (int m = 0; m < 4; m++) begin
         mac_u.wr(OFS_TX_CONFIG, 8'(m << 5));
         for (int v = 0; v < 8; v++) begin
            @(posedge i_clk_sys);
            det <= 3'(v);
            settle(2);
            e = m == 0 ? v[2] : m == 1 ? |v[1:0] : m == 2 ? v[2] & |v[1:0] : |v[2:0];
            chk(cca, e);
         end
      end
   endtask
   // Sampled assessment holds until the sample point of the slot
   task automatic t_samp(input logic [7:0] c, input int at);
      mac_u.wr(OFS_TX_CONFIG, c);
      mac_u.wr(OFS_RX_TX_CONFIG, 8'h08);
      @(posedge i_clk_sys);
      det <= 3'h0;
      pulse(3'h4);
      repeat (at + 5) @(posedge i_clk_sys);
      det <= 3'h4;
      pulse(3'h4);
      settle(at - 5);
      chk(cca, 0);
      settle(10);
      chk(cca, 1);
   endtask
   task automatic t_ant(input logic [7:0] t, input logic [7:0] r, input logic h, input logic d, input logic e);
      mac_u.wr(OFS_TX_CONFIG, t);
      mac_u.wr(OFS_RX_CONFIG, r);
      @(posedge i_clk_sys);
      half <= h;
      div_ant <= d;
      settle(3);
      chk(ant, e);
      chk(div_act, !r[0] && !(r[2] && h));
   endtask
   task automatic t_rx();
      pulse(3'h4);
      mac_u.wr(OFS_RX_CONFIG, 8'hf8);
      mac_u.wr(OFS_RX_TX_CONFIG, 8'h00);
      settle(2);
      chk(rx, 11'h440);
      pulse(3'h2);
      chk(rdy, 1);
      settle(1);
      chk(rx.est_clk_en, 1);
      pulse(3'h4);
      mac_u.wr(OFS_RX_TX_CONFIG, 8'hd7);
      settle(2);
      chk(rx, 11'h65f);
      chk(tx.long_len_for_short, 1);
      mac_u.wr(OFS_RX_CONFIG, 8'h00);
      settle(2);
      chk({rx.isi_eq_en, rx.ici_eq_en}, 2'h3);
      pulse(3'h2);
      chk(rdy, 0);
      pulse(3'h1);
      chk(rdy, 1);
   endtask
   task automatic t_conv(input logic [7:0] c, input logic s, input logic [7:0] e, input logic es);
      mac_u.wr(OFS_CONVERTER_CLOCK_TEST, c);
      @(posedge i_clk_sys);
      ser <= s;
      settle(4);
      chk(conv, e);
      chk(csrc, es);
   endtask
   task automatic test_done();
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      n_errors++;
      test_done();
   end
   initial begin
      i_rst_n = 1'b0;
      {pls, crc_ant, half, div_ant, ser, det} = '0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      t_regs();
      t_tx(8'h08, 3'h5);
      t_tx(8'h18, 3'h6);
      t_tx(8'h10, 3'h0);
      t_cca();
      t_samp(8'h00, SAMPLE_LATE_CYC);
      t_samp(8'h80, SAMPLE_EARLY_CYC);
      t_ant(8'h0c, 8'h00, 1'b0, 1'b0, 1'b1);
      t_ant(8'h08, 8'h00, 1'b0, 1'b1, 1'b0);
      t_ant(8'h00, 8'h03, 1'b0, 1'b0, 1'b1);
      t_ant(8'h00, 8'h01, 1'b0, 1'b1, 1'b0);
      t_ant(8'h00, 8'h04, 1'b0, 1'b1, 1'b1);
      t_ant(8'h04, 8'h04, 1'b1, 1'b0, 1'b1);
      @(posedge i_clk_sys);
      crc_ant <= 1'b1;
      pulse(3'h1);
      t_ant(8'h02, 8'h04, 1'b1, 1'b0, 1'b1);
      @(posedge i_clk_sys);
      crc_ant <= 1'b0;
      pulse(3'h1);
      t_ant(8'h02, 8'h04, 1'b1, 1'b1, 1'b0);
      t_rx();
      t_conv(8'h85, 1'b1, 8'hfa, 1'b1);
      t_conv(8'h85, 1'b0, 8'hfa, 1'b0);
      t_conv(8'h00, 1'b1, 8'h7f, 1'b0);
      test_done();
   end
endmodule
